/* File: rtl/ipr_pkg.sv */
package ipr_pkg;
   localparam int SRC_COUNT     = 45;
   localparam int CPU_SRC_COUNT = 9;
   localparam int INT_SRC_COUNT = 26;
   localparam int EXT_SRC_COUNT = 10;
   localparam int NMI_PIN_INDEX = 8;
   localparam int WDT_INDEX     = 9;
   localparam int NMASK_COUNT   = 10;
   localparam int VEC_STEP      = 4;
   localparam int XFER_CHANNELS = 4;
   localparam logic [2:0] MASK_RESET   = 3'h7;
   localparam logic [2:0] LEVEL_NMI    = 3'h7;
   localparam logic [2:0] LEVEL_OFF    = 3'h0;
   localparam logic [2:0] LEVEL_MAX_M  = 3'h6;
   localparam logic [7:0] VEC_NONE     = 8'h00;
   localparam logic [1:0] SIZE_BYTE    = 2'h0;
   localparam logic [1:0] SIZE_WORD    = 2'h1;
   localparam logic [1:0] SIZE_LONG    = 2'h2;

   typedef struct packed {
      logic       valid;
      logic [2:0] level;
      logic [5:0] index;
      logic [7:0] vector;
   } ipr_req_type;

   typedef struct packed {
      logic       start;
      logic [5:0] index;
      logic [1:0] size;
   } ipr_xfer_type;
endpackage : ipr_pkg

/* File: rtl/ipr_resolver.sv */
`timescale 1ns/1ps
module ipr_resolver
   import ipr_pkg::*;
(
   // clock and reset
   input  wire logic                   REF_CLK,
   input  wire logic                   RST_N,
   // request sources
   input  wire logic [SRC_COUNT-1:0]   SRC_REQ,
   input  wire logic [3*SRC_COUNT-1:0] SRC_LEVEL,
   // transfer mode selection per source
   input  wire logic [SRC_COUNT-1:0]   XFER_ENABLE,
   input  wire logic [2*SRC_COUNT-1:0] XFER_SIZE,
   input  wire logic                   SOFT_XFER_REQ,
   input  wire logic [5:0]             SOFT_XFER_INDEX,
   // core side
   input  wire logic                   INSN_BOUNDARY,
   input  wire logic                   SET_MASK,
   input  wire logic [2:0]             SET_MASK_VALUE,
   input  wire logic                   MASK_ALL,
   input  wire logic                   RESTORE_MASK,
   input  wire logic [2:0]             RESTORE_VALUE,
   // outputs
   output ipr_req_type                 PENDING,
   output logic                        ACCEPT,
   output logic [7:0]                  ACCEPT_VECTOR,
   output ipr_xfer_type                XFER,
   output logic [2:0]                  INTERRUPT_MASK_LEVEL
);

   logic                 rst_meta_reg;
   logic                 rst_sync_reg;
   logic                 rst_n;
   logic [SRC_COUNT-1:0] pend_reg;
   logic [SRC_COUNT-1:0] req_eff;
   logic [2:0]           lvl         [SRC_COUNT];
   logic [2:0]           interrupt_mask_level_reg;
   logic [2:0]           interrupt_mask_level_next;
   ipr_req_type          best;
   ipr_req_type          pending_reg;
   logic                 take;
   logic                 accept_reg;
   logic [7:0]           accept_vector_reg;
   ipr_xfer_type         xfer_reg;

   function automatic logic is_nmask(input int idx);
      return idx < NMASK_COUNT;
   endfunction : is_nmask

   function automatic logic [7:0] vec_of(input logic [5:0] idx);
      return 8'(idx) * 8'(VEC_STEP);
   endfunction : vec_of

   // reset released through two flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // per-source level and eligibility
   for (genvar g = 0; g < SRC_COUNT; g++) begin : g_src
      if (g < NMASK_COUNT) begin : g_nm
         assign lvl[g]     = LEVEL_NMI;
         assign req_eff[g] = pend_reg[g];
      end else begin : g_m
         assign lvl[g]     = SRC_LEVEL[3*g +: 3];
         // levels 0 and 7 leave the source silent
         assign req_eff[g] = pend_reg[g] && lvl[g] != LEVEL_OFF
                             && lvl[g] != LEVEL_NMI;
      end
   end

   // highest level wins; strict compare keeps lowest index on ties
   always_comb begin
      best = '0;
      for (int i = 0; i < SRC_COUNT; i++) begin
         if (req_eff[i] && (!best.valid || lvl[i] > best.level)) begin
            best.valid  = 1'b1;
            best.level  = lvl[i];
            best.index  = 6'(i);
            best.vector = vec_of(6'(i));
         end
      end
   end

   // acceptance only at an instruction boundary
   assign take = INSN_BOUNDARY && best.valid
                 && best.level >= interrupt_mask_level_reg;

   // pending latches: a new request beats the clear of the taken one
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= '0;
      end else begin
         for (int i = 0; i < SRC_COUNT; i++) begin
            if (SRC_REQ[i])
               pend_reg[i] <= 1'b1;
            else if (take && best.index == 6'(i))
               pend_reg[i] <= 1'b0;
         end
      end
   end

   // mask field of the status word
   always_comb begin
      interrupt_mask_level_next = interrupt_mask_level_reg;
      if (take) begin
         if (best.level == LEVEL_NMI)
            interrupt_mask_level_next = LEVEL_NMI;
         else
            interrupt_mask_level_next = best.level + 3'h1;
      end else if (MASK_ALL) begin
         interrupt_mask_level_next = MASK_RESET;
      end else if (SET_MASK) begin
         interrupt_mask_level_next = SET_MASK_VALUE;
      end else if (RESTORE_MASK) begin
         interrupt_mask_level_next = RESTORE_VALUE;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n)
         interrupt_mask_level_reg <= MASK_RESET;
      else
         interrupt_mask_level_reg <= interrupt_mask_level_next;
   end

   // accept strobe and vector
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         accept_reg        <= 1'b0;
         accept_vector_reg <= VEC_NONE;
         pending_reg       <= '0;
      end else begin
         accept_reg  <= take;
         pending_reg <= best;
         if (take)
            accept_vector_reg <= best.vector;
      end
   end

   // transfer mode: hardware accept or software start; hardware has
   // priority, software starts only when no transfer-mode accept happens this cycle
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         xfer_reg <= '0;
      end else begin
         xfer_reg.start <= 1'b0;
         if (take && XFER_ENABLE[best.index] && !is_nmask(int'(best.index)))
         begin
            xfer_reg.start <= 1'b1;
            xfer_reg.index <= best.index;
            xfer_reg.size  <= XFER_SIZE[2*best.index +: 2];
         end else if (SOFT_XFER_REQ
                      && SOFT_XFER_INDEX < 6'(SRC_COUNT)) begin
            xfer_reg.start <= 1'b1;
            xfer_reg.index <= SOFT_XFER_INDEX;
            xfer_reg.size  <= XFER_SIZE[2*SOFT_XFER_INDEX +: 2];
         end
      end
   end

   assign PENDING              = pending_reg;
   assign ACCEPT               = accept_reg;
   assign ACCEPT_VECTOR        = accept_vector_reg;
   assign XFER                 = xfer_reg;
   assign INTERRUPT_MASK_LEVEL = interrupt_mask_level_reg;

endmodule : ipr_resolver

/* File: verification/ipr_core_model.sv */
`timescale 1ns/1ps
module ipr_core_model (
   // clock and run control
   input  wire logic clk,
   input  wire logic run,
   // boundary strobe
   output logic      boundary = 1'b0
);
   // run low models a long instruction, so requests wait
   always_ff @(posedge clk) begin
      boundary <= run;
   end
endmodule : ipr_core_model

/* File: verification/ipr_resolver_asserts.sv */
`timescale 1ns/1ps
module ipr_chk
   import ipr_pkg::*;
(
   // watched ports
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        INSN_BOUNDARY,
   input wire logic        MASK_ALL,
   input wire ipr_req_type PENDING,
   input wire logic        ACCEPT,
   input wire logic [7:0]  ACCEPT_VECTOR,
   input wire logic [2:0]  INTERRUPT_MASK_LEVEL
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // pending shows the winner one cycle late, so the boundary and the
   // mask that met it are taken from the cycle before
   sequence s_hit;
      $past(INSN_BOUNDARY) && PENDING.valid
      && PENDING.level >= $past(INTERRUPT_MASK_LEVEL);
   endsequence
   property p_take; s_hit |-> ACCEPT; endproperty
   a_take: assert property (p_take) else $error("lost");
   property p_why; ACCEPT |-> s_hit; endproperty
   a_why: assert property (p_why) else $error("stray");
   property p_vec; ACCEPT |-> ACCEPT_VECTOR == PENDING.vector;
   endproperty
   a_vec: assert property (p_vec) else $error("vector");
   property p_map; PENDING.valid |-> PENDING.vector == {PENDING.index, 2'h0};
   endproperty
   a_map: assert property (p_map) else $error("map");
   property p_nest; ACCEPT |-> INTERRUPT_MASK_LEVEL ==
      (PENDING.level == 3'h7 ? 3'h7 : PENDING.level + 3'h1);
   endproperty
   a_nest: assert property (p_nest) else $error("nest");
   property p_nmi; PENDING.valid && PENDING.index < 6'h0A |->
      PENDING.level == 3'h7; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi");
   property p_lvl; PENDING.valid |-> PENDING.level != 3'h0 &&
      (PENDING.index < 6'h0A || PENDING.level != 3'h7); endproperty
   a_lvl: assert property (p_lvl) else $error("level");
   property p_all; $past(MASK_ALL) && !ACCEPT |->
      INTERRUPT_MASK_LEVEL == 3'h7;
   endproperty
   a_all: assert property (p_all) else $error("mask all");
endmodule : ipr_chk
bind ipr_resolver ipr_chk u_chk (.*);

/* File: verification/interrupt_priority_resolver_tb.sv */
`timescale 1ns/1ps
module interrupt_priority_resolver_tb;
   import ipr_pkg::*;
   logic                   clk = 1'b0, rst_n = 1'b0, run = 1'b0, bnd, acc;
   logic                   sm = 1'b0, ma = 1'b0, sx = 1'b0;
   logic [SRC_COUNT-1:0]   req = '0;
   logic [3*SRC_COUNT-1:0] lvl = '0;
   logic [SRC_COUNT-1:0]   xe = '0;
   logic [2*SRC_COUNT-1:0] xs = '0;
   logic [2:0]             sv = 3'h0, mask;
   logic [7:0]             vec;
   ipr_req_type            pend;
   ipr_xfer_type           xf;
   int                     bad_count = 0, n_checks = 0, cyc = 0;
   always #12.5 clk = ~clk;
   ipr_core_model core (.clk(clk), .run(run), .boundary(bnd));
   ipr_resolver DUT (.REF_CLK(clk), .RST_N(rst_n), .SRC_REQ(req),
      .SRC_LEVEL(lvl), .XFER_ENABLE(xe), .XFER_SIZE(xs),
      .SOFT_XFER_REQ(sx), .SOFT_XFER_INDEX(6'h0C), .INSN_BOUNDARY(bnd),
      .SET_MASK(sm), .SET_MASK_VALUE(sv), .MASK_ALL(ma),
      .RESTORE_MASK(1'b0), .RESTORE_VALUE(3'h0), .PENDING(pend),
      .ACCEPT(acc), .ACCEPT_VECTOR(vec), .XFER(xf),
      .INTERRUPT_MASK_LEVEL(mask));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic src(input int i, input logic [2:0] l);
      @(posedge clk);
      lvl[i*3+:3] <= l;
      req[i] <= 1'b1;
      @(posedge clk);
      req[i] <= 1'b0;
   endtask : src
   task automatic setm(input logic [2:0] v);
      @(posedge clk);
      sm <= 1'b1;
      sv <= v;
      @(posedge clk);
      sm <= 1'b0;
   endtask : setm
   // bounded wait so a lost accept shows as a mismatch, not a hang
   task automatic wacc(input logic [7:0] v, input logic [2:0] m);
      int k = 0;
      #1;
      while (acc !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk({7'h0, acc}, 8'h01);
      chk(vec, v);
      chk(mask, m);
   endtask : wacc
   task automatic t_walk();
      chk(mask, 8'h07);
      setm(3'h0);
      run <= 1'b1;
      src(12, 3'h3);
      wacc(8'h30, 3'h4);
      $display("walk done");
   endtask : t_walk
   task automatic t_prio();
      @(posedge clk);
      run <= 1'b0;
      setm(3'h0);
      src(20, 3'h5);
      src(15, 3'h5);
      src(30, 3'h2);
      repeat (2) @(posedge clk);
      #1;
      chk(pend.index, 8'h0F);
      chk(pend.level, 8'h05);
      chk(pend.vector, 8'h3C);
      @(posedge clk);
      run <= 1'b1;
      wacc(8'h3C, 3'h6);
      repeat (3) @(posedge clk);
      #1;
      chk(pend.index, 8'h14);
      setm(3'h5);
      wacc(8'h50, 3'h6);
      $display("prio done");
   endtask : t_prio
   task automatic t_mask();
      @(posedge clk);
      ma <= 1'b1;
      @(posedge clk);
      ma <= 1'b0;
      src(40, 3'h7);
      src(41, 3'h0);
      repeat (2) @(posedge clk);
      #1;
      chk(pend.index, 8'h1E);
      src(8, 3'h0);
      wacc(8'h20, 3'h7);
      @(posedge clk);
      sx <= 1'b1;
      @(posedge clk);
      sx <= 1'b0;
      #1;
      chk({1'b0, xf.start, xf.index}, 8'h4C);
      @(posedge clk);
      #1;
      chk({7'h0, xf.start}, 8'h00);
      $display("mask done");
   endtask : t_mask
   task automatic t_xfer();
      @(posedge clk);
      xe[30] <= 1'b1;
      xs[2*30+:2] <= SIZE_LONG;
      setm(3'h2);
      wacc(8'h78, 3'h3);
      chk({1'b0, xf.start, xf.index}, 8'h5E);
      chk({6'h0, xf.size}, {6'h0, SIZE_LONG});
      @(posedge clk);
      #1;
      chk({7'h0, acc}, 8'h00);
      chk({7'h0, xf.start}, 8'h00);
      $display("xfer done");
   endtask : t_xfer
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_walk();
      t_prio();
      t_mask();
      t_xfer();
      wrap_up();
   end
endmodule : interrupt_priority_resolver_tb
